// *** hdl/sbit_defines.svh ***
// Constants of the sixteen-bit interval timer: offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from every file that needs a number of the block.
`ifndef SBIT_DEFINES_SVH
`define SBIT_DEFINES_SVH
`define SBIT_ADDR_W          3
`define SBIT_OFF_GLOBAL_CTRL 3'h0
`define SBIT_OFF_PERIPH_IE   3'h1
`define SBIT_OFF_PERIPH_FLAG 3'h2
`define SBIT_OFF_COUNT_LO    3'h3
`define SBIT_OFF_COUNT_HI    3'h4
`define SBIT_OFF_TIMER_CTRL  3'h5
`define SBIT_BIT_RUN         0
`define SBIT_BIT_SRC         1
`define SBIT_BIT_PS_LO       4
`define SBIT_BIT_PS_HI       5
`define SBIT_BIT_GIE         7
`define SBIT_BIT_PERIPHERAL_INTERRUPT_ENABLE        6
`define SBIT_BIT_ROLL        0
`define SBIT_CTRL_WMASK      8'h33
`define SBIT_CTRL_RESET      8'h00
`define SBIT_COUNT_RESET     16'h0000
`define SBIT_COUNT_MAX       16'hFFFF
`define SBIT_MCLK_MHZ        100
`define SBIT_SYS_MHZ         8
`define SBIT_INSTR_DIV       4
`endif

// *** hdl/sbit_pkg.sv ***
// Types shared by the interval timer modules.
// Assumes nothing of its surroundings.
package sbit_pkg;
   typedef logic [7:0]  sbit_byte_t;
   typedef logic [15:0] sbit_count_t;
   typedef enum logic [1:0] {SBIT_PS_DIV1, SBIT_PS_DIV2, SBIT_PS_DIV4, SBIT_PS_DIV8} sbit_prescale_e;
endpackage : sbit_pkg

// *** hdl/sbit_if.sv ***
// Carriers between the timer top, its tick generator and its counter.
// Assumes all three modules run on the one master clock.
`timescale 1ns/10ps
interface sbit_tick_if;
   import sbit_pkg::*;
   logic           gate;      // Counting gate.
   logic           src_sys;   // 1 selects system clock rate.
   sbit_prescale_e prescale;  // Prescale division.
   logic           presc_clr; // Clears the prescaler.
   logic           sleep;     // Freezes all rates.
   logic           tick;      // One-cycle count enable.
   modport ctrl (output gate, src_sys, prescale, presc_clr, sleep, input tick);
   modport gen  (input gate, src_sys, prescale, presc_clr, sleep, output tick);
endinterface : sbit_tick_if

interface sbit_cnt_if;
   import sbit_pkg::*;
   logic        tick;     // Increment enable.
   logic        load_lo;  // Load low byte.
   logic        load_hi;  // Load high byte.
   sbit_byte_t  wdata;    // Byte to load.
   sbit_count_t count;    // Live count.
   logic        rollover; // Wrap pulse.
   modport ctrl (output tick, load_lo, load_hi, wdata, input count, rollover);
   modport cnt  (input tick, load_lo, load_hi, wdata, output count, rollover);
endinterface : sbit_cnt_if

// *** hdl/sbit_tick_gen.sv ***
// Count-rate generator: system and instruction rates from the master clock, source choice, prescaler.
// Assumes a 100 MHz master clock; the 8 MHz rate is made by a fractional accumulator.
`timescale 1ns/10ps
`include "sbit_defines.svh"
module sbit_tick_gen
   import sbit_pkg::*;
(
   input  wire logic  i_mclk,  // Master clock.
   input  wire logic  i_rst_n, // Synchronised reset, active low.
   sbit_tick_if.gen   tif      // Control and tick.
);
   localparam logic [7:0] STEP = 8'(`SBIT_SYS_MHZ);
   localparam logic [7:0] MODU = 8'(`SBIT_MCLK_MHZ);

   function automatic logic [2:0] presc_limit(input sbit_prescale_e ps);
      return 3'((4'h1 << ps) - 4'h1);
   endfunction : presc_limit

   logic [7:0] acc_reg;
   logic [1:0] quarter_reg;
   logic [2:0] presc_reg;
   logic [7:0] acc_sum;
   logic       sys_tick;
   logic       instr_tick;
   logic       src_tick;

   assign acc_sum    = acc_reg + STEP;
   assign sys_tick   = !tif.sleep && (acc_sum >= MODU);
   assign instr_tick = sys_tick && (quarter_reg == 2'(`SBIT_INSTR_DIV - 1));
   assign src_tick   = tif.src_sys ? sys_tick : instr_tick;
   assign tif.tick   = tif.gate && !tif.presc_clr && src_tick
                       && (presc_reg == presc_limit(tif.prescale));

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_reg <= 8'h00;
      end else if (!tif.sleep) begin
         acc_reg <= sys_tick ? acc_sum - MODU : acc_sum;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         quarter_reg <= 2'h0;
      end else if (sys_tick) begin
         quarter_reg <= quarter_reg + 2'h1;
      end
   end

   // The prescaler has no software path; it only clears or advances.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         presc_reg <= 3'h0;
      end else if (tif.presc_clr || !tif.gate) begin
         presc_reg <= 3'h0;
      end else if (src_tick) begin
         presc_reg <= (presc_reg == presc_limit(tif.prescale)) ? 3'h0 : presc_reg + 3'h1;
      end
   end
endmodule : sbit_tick_gen

// *** hdl/sbit_counter.sv ***
// Sixteen-bit up counter with byte loads and a rollover pulse.
// Assumes load strobes come from register writes and take priority over the tick.
`timescale 1ns/10ps
`include "sbit_defines.svh"
module sbit_counter
   import sbit_pkg::*;
(
   input  wire logic i_mclk,  // Master clock.
   input  wire logic i_rst_n, // Synchronised reset, active low.
   sbit_cnt_if.cnt   cif      // Loads, tick and count.
);
   sbit_count_t count_reg;
   logic        loading;

   assign loading      = cif.load_lo || cif.load_hi;
   assign cif.count    = count_reg;
   assign cif.rollover = cif.tick && !loading && (count_reg == `SBIT_COUNT_MAX);

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_reg <= `SBIT_COUNT_RESET;
      end else if (loading) begin
         if (cif.load_lo) begin
            count_reg[7:0] <= cif.wdata;
         end
         if (cif.load_hi) begin
            count_reg[15:8] <= cif.wdata;
         end
      end else if (cif.tick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end
endmodule : sbit_counter

// *** hdl/sbit_timer.sv ***
// Top of the sixteen-bit interval timer: register port, control, flag and interrupt request.
// Assumes a synchronous register master, one strobe per cycle, read data sampled one cycle later.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "sbit_defines.svh"
module sbit_timer
   import sbit_pkg::*;
(
   input  wire logic                    i_mclk,    // Master clock, 100 MHz.
   input  wire logic                    i_reset_n, // Asynchronous reset, active low.
   input  wire logic [`SBIT_ADDR_W-1:0] i_addr,    // Register address.
   input  wire logic [7:0]              i_wdata,   // Write data.
   input  wire logic                    i_wr,      // Write strobe.
   input  wire logic                    i_rd,      // Read strobe.
   input  wire logic                    i_sleep,   // Device in sleep.
   output logic      [7:0]              o_rdata,   // Read data, one cycle after the strobe.
   output logic                         o_irq,     // Rollover interrupt request.
   output logic      [15:0]             o_count    // Registered count for other units.
);
   // Reset release through two flip-flops.
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   function automatic logic hit(input logic [`SBIT_ADDR_W-1:0] a, input logic [`SBIT_ADDR_W-1:0] off);
      return a == off;
   endfunction : hit

   // Write decode.
   logic wr_gctrl;
   logic wr_pie;
   logic wr_pflag;
   logic wr_lo;
   logic wr_hi;
   logic wr_tctrl;

   assign wr_gctrl = i_wr && hit(i_addr, `SBIT_OFF_GLOBAL_CTRL);
   assign wr_pie   = i_wr && hit(i_addr, `SBIT_OFF_PERIPH_IE);
   assign wr_pflag = i_wr && hit(i_addr, `SBIT_OFF_PERIPH_FLAG);
   assign wr_lo    = i_wr && hit(i_addr, `SBIT_OFF_COUNT_LO);
   assign wr_hi    = i_wr && hit(i_addr, `SBIT_OFF_COUNT_HI);
   assign wr_tctrl = i_wr && hit(i_addr, `SBIT_OFF_TIMER_CTRL);

   // Control register: run enable, clock source, prescale field.
   logic [7:0] tctrl_reg;
   logic       run_enable;
   logic       clock_source_select;
   logic [1:0] prescale_select;

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         tctrl_reg <= `SBIT_CTRL_RESET;
      end else if (wr_tctrl) begin
         tctrl_reg <= i_wdata & `SBIT_CTRL_WMASK;
      end
   end

   assign run_enable          = tctrl_reg[`SBIT_BIT_RUN];
   assign clock_source_select = tctrl_reg[`SBIT_BIT_SRC];
   assign prescale_select     = tctrl_reg[`SBIT_BIT_PS_HI:`SBIT_BIT_PS_LO];

   // Gate flip-flop: follows run enable; a write of zero clears it in the same edge.
   logic gate_reg;

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         gate_reg <= 1'b0;
      end else if (wr_tctrl) begin
         gate_reg <= i_wdata[`SBIT_BIT_RUN];
      end else begin
         gate_reg <= run_enable;
      end
   end

   // Global and peripheral enables.
   logic global_interrupt_enable;
   logic peripheral_interrupt_enable;
   logic rollover_interrupt_enable;

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         global_interrupt_enable     <= 1'b0;
         peripheral_interrupt_enable <= 1'b0;
      end else if (wr_gctrl) begin
         global_interrupt_enable     <= i_wdata[`SBIT_BIT_GIE];
         peripheral_interrupt_enable <= i_wdata[`SBIT_BIT_PERIPHERAL_INTERRUPT_ENABLE];
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         rollover_interrupt_enable <= 1'b0;
      end else if (wr_pie) begin
         rollover_interrupt_enable <= i_wdata[`SBIT_BIT_ROLL];
      end
   end

   // Tick generator and counter.
   sbit_tick_if tif ();
   sbit_cnt_if  cif ();

   assign tif.gate      = gate_reg && run_enable;
   assign tif.src_sys   = clock_source_select;
   assign tif.prescale  = sbit_prescale_e'(prescale_select);
   assign tif.presc_clr = wr_lo || wr_hi;
   assign tif.sleep     = i_sleep;

   assign cif.tick    = tif.tick;
   assign cif.load_lo = wr_lo;
   assign cif.load_hi = wr_hi;
   assign cif.wdata   = i_wdata;

   sbit_tick_gen u_tick_gen (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_n),
      .tif     (tif.gen)
   );

   sbit_counter u_counter (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_n),
      .cif     (cif.cnt)
   );

   // Rollover flag: hardware sets, software writes; a set in the clearing cycle wins.
   logic rollover_flag;

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         rollover_flag <= 1'b0;
      end else if (cif.rollover) begin
         rollover_flag <= 1'b1;
      end else if (wr_pflag) begin
         rollover_flag <= i_wdata[`SBIT_BIT_ROLL];
      end
   end

   // The request is held low while run enable is clear; sleep does not gate it, though the count is frozen there.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= rollover_flag && run_enable && rollover_interrupt_enable
                  && peripheral_interrupt_enable && global_interrupt_enable;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_count <= `SBIT_COUNT_RESET;
      end else begin
         o_count <= cif.count;
      end
   end

   // Read path: data stands only in the cycle after the strobe; unmapped reads return zero.
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      unique case (i_addr)
         `SBIT_OFF_GLOBAL_CTRL: begin
            rd_mux[`SBIT_BIT_GIE]  = global_interrupt_enable;
            rd_mux[`SBIT_BIT_PERIPHERAL_INTERRUPT_ENABLE] = peripheral_interrupt_enable;
         end
         `SBIT_OFF_PERIPH_IE: begin
            rd_mux[`SBIT_BIT_ROLL] = rollover_interrupt_enable;
         end
         `SBIT_OFF_PERIPH_FLAG: begin
            rd_mux[`SBIT_BIT_ROLL] = rollover_flag;
         end
         `SBIT_OFF_COUNT_LO: begin
            rd_mux = cif.count[7:0];
         end
         `SBIT_OFF_COUNT_HI: begin
            rd_mux = cif.count[15:8];
         end
         `SBIT_OFF_TIMER_CTRL: begin
            rd_mux = tctrl_reg;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= i_rd ? rd_mux : 8'h00;
      end
   end
endmodule : sbit_timer

// *** verif/sbit_timer_properties.sv ***
// Checker of the interval timer top: read port, count steps, freezes and request gating.
// Assumes a bind to sbit_timer; it sees only that module's ports.
`timescale 1ns/10ps
`include "sbit_defines.svh"
module sbit_timer_properties (
   input wire logic                    i_mclk,
   input wire logic                    i_reset_n,
   input wire logic [`SBIT_ADDR_W-1:0] i_addr,
   input wire logic [7:0]              i_wdata,
   input wire logic                    i_wr,
   input wire logic                    i_rd,
   input wire logic                    i_sleep,
   input wire logic [7:0]              o_rdata,
   input wire logic                    o_irq,
   input wire logic [15:0]             o_count
);
   logic run_q, gie_q, pe_q, rie_q;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   // Shadow copies of the enable bits, taken from register writes.
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         {run_q, gie_q, pe_q, rie_q} <= 4'h0;
      end else if (i_wr) begin
         if (i_addr == `SBIT_OFF_TIMER_CTRL) run_q <= i_wdata[0];
         if (i_addr == `SBIT_OFF_GLOBAL_CTRL) {gie_q, pe_q} <= i_wdata[7:6];
         if (i_addr == `SBIT_OFF_PERIPH_IE) rie_q <= i_wdata[0];
      end
   end
   ctrl_zero_a: assert property ($past(i_rd) && $past(i_addr) == 3'h5 |-> (o_rdata & 8'hCC) == 8'h00)
      else $error("control spare bits read set");
   unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) > 3'h5 |-> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   count_step_a: assert property (!$past(i_wr, 2) && o_count != $past(o_count)
      |-> o_count == $past(o_count) + 16'h0001) else $error("count jumped");
   stop_hold_a: assert property (!$past(run_q, 2) && !$past(run_q, 3) && !$past(i_wr, 2)
      |-> $stable(o_count)) else $error("count moved while stopped");
   sleep_hold_a: assert property ($past(i_sleep, 2) && $past(i_sleep, 3) && $past(i_sleep, 4)
      && !$past(i_wr, 2) |-> $stable(o_count)) else $error("count moved in sleep");
   irq_run_a: assert property (o_irq |-> $past(run_q)) else $error("request while stopped");
   irq_enables_a: assert property (o_irq |-> $past(gie_q) && $past(pe_q) && $past(rie_q))
      else $error("request with an enable clear");
   wrap_irq_a: assert property ($past(o_count) == 16'hFFFF && o_count == 16'h0000
      && run_q && gie_q && pe_q && rie_q |-> ##[0:3] o_irq) else $error("no request after wrap");
   wrap_c: cover property ($past(o_count) == 16'hFFFF && o_count == 16'h0000);
   irq_c: cover property ($rose(o_irq));
   sleep_c: cover property (i_sleep && o_count != 16'h0000);
endmodule : sbit_timer_properties

bind sbit_timer sbit_timer_properties u_sbit_timer_properties (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_sleep(i_sleep), .o_rdata(o_rdata),
   .o_irq(o_irq), .o_count(o_count));

// *** verif/sbit_timer_tb.sv ***
// Bench of the interval timer: register model, rates, wrap, request gating, sleep, reset.
// Assumes the timer top and its checker are compiled first.
`timescale 1ns/10ps
module sbit_timer_tb;
   logic        i_mclk, i_reset_n, i_wr, i_rd, i_sleep, o_irq;
   logic [2:0]  i_addr;
   logic [7:0]  i_wdata, o_rdata;
   logic [15:0] o_count, v;
   logic [7:0]  msk [8] = '{8'hC0, 8'h01, 8'h01, 8'hFF, 8'hFF, 8'h33, 8'h00, 8'h00};
   int          fail_count, checks_done, seed, n, e, rv, mdl [8];
   sbit_timer u_sbit_timer (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_sleep(i_sleep), .o_rdata(o_rdata), .o_irq(o_irq), .o_count(o_count));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic tk(input int c);
      repeat (c) @(posedge i_mclk);
      #1;
   endtask : tk
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] s, input bit t);
      checks_done++;
      if (s !== ex && (!t || (s !== ex + 16'h1 && s !== ex - 16'h1))) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, s);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      mdl[a] = d & msk[a];
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] ex);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk("rdata", {8'h00, ex}, {8'h00, o_rdata}, 1'b0);
   endtask : rd
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      {i_wr, i_rd, i_sleep, i_reset_n} = 4'h0;
      i_addr = 3'h0;
      i_wdata = 8'h00;
      seed = 32'h58CA2B72;
      fail_count = 0;
      checks_done = 0;
      foreach (mdl[a]) mdl[a] = 0;
      repeat (3) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      tk(3);
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      chk("count", 16'h0000, o_count, 1'b0);
      for (int a = 0; a < 8; a++) begin
         rv = $random(seed);
         wr(a[2:0], rv[7:0]);
         rd(a[2:0], mdl[a][7:0]);
         if (a == 4) chk("count", {mdl[4][7:0], mdl[3][7:0]}, o_count, 1'b0);
      end
      for (int a = 5; a >= 0; a--) wr(a[2:0], 8'h00);
      $display("register test done");
      for (int m = 0; m < 8; m++) begin
         wr(3'h3, 8'h00);
         wr(3'h4, 8'h00);
         wr(3'h5, {2'b00, m[1:0], 2'b00, m[2], 1'b1});
         tk(2000);
         wr(3'h5, 8'h00);
         e = (2002 * 8 / 100) >> (m[1:0] + (m[2] ? 0 : 2));
         chk("rate", e[15:0], o_count, 1'b1);
         // A tick taken at the stopping edge still reaches the registered count one cycle later.
         tk(1);
         v = o_count;
         tk(50);
         chk("stopped", v, o_count, 1'b0);
      end
      $display("rate test done");
      wr(3'h3, 8'hFE);
      wr(3'h4, 8'hFF);
      wr(3'h0, 8'hC0);
      wr(3'h1, 8'h01);
      wr(3'h5, 8'h03);
      for (n = 0; n < 100 && o_irq !== 1'b1; n++) tk(1);
      if (n == 100) begin
         $display("ERROR irq wait expected 1 seen 0");
         fail_count++;
         tally_and_finish();
      end
      chk("wrap", 16'h0000, o_count, 1'b1);
      mdl[2] = 1;
      rd(3'h2, mdl[2][7:0]);
      wr(3'h5, 8'h00);
      tk(1);
      chk("irq", 16'h0000, {15'h0, o_irq}, 1'b0);
      rd(3'h2, 8'h01);
      wr(3'h5, 8'h03);
      for (int k = 0; k < 3; k++) begin
         wr(k == 2 ? 3'h1 : 3'h0, k == 2 ? 8'h00 : 8'h80 >> k);
         tk(1);
         chk("irq", 16'h0000, {15'h0, o_irq}, 1'b0);
         wr(k == 2 ? 3'h1 : 3'h0, k == 2 ? 8'h01 : 8'hC0);
         tk(1);
         chk("irq", 16'h0001, {15'h0, o_irq}, 1'b0);
      end
      wr(3'h2, 8'h00);
      tk(1);
      chk("irq", 16'h0000, {15'h0, o_irq}, 1'b0);
      $display("rollover test done");
      @(posedge i_mclk);
      i_sleep <= 1'b1;
      rv = $random(seed);
      wr(3'h4, rv[15:8]);
      wr(3'h3, rv[7:0]);
      tk(300);
      chk("sleep", rv[15:0], o_count, 1'b0);
      @(posedge i_mclk);
      i_sleep <= 1'b0;
      tk(100);
      chk("wake", rv[15:0] + 16'h8, o_count, 1'b1);
      $display("sleep test done");
      // Eight system ticks span exactly 100 cycles, so a count write halfway must push the next step out.
      wr(3'h5, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h00);
      wr(3'h5, 8'h33);
      for (n = 0; n < 200 && o_count !== 16'h0001; n++) tk(1);
      if (n == 200) begin
         $display("ERROR first tick expected 0001 seen %h", o_count);
         fail_count++;
         tally_and_finish();
      end
      tk(40);
      wr(3'h3, 8'h00);
      tk(60);
      chk("presc clear", 16'h0000, o_count, 1'b0);
      tk(50);
      chk("presc clear", 16'h0001, o_count, 1'b0);
      $display("prescaler test done");
      @(posedge i_mclk);
      i_reset_n <= 1'b0;
      tk(2);
      @(posedge i_mclk);
      i_reset_n <= 1'b1;
      tk(3);
      rd(3'h5, 8'h00);
      chk("count", 16'h0000, o_count, 1'b0);
      $display("reset test done");
      tally_and_finish();
   end
endmodule : sbit_timer_tb
